// ### rtl/asbp_pkg.sv
// shared constants and types for the sram controller
package asbp_pkg;
  localparam int unsigned ADDR_W = 18;
  localparam int unsigned DATA_W = 16;
  localparam int unsigned BYTE_W = 8;
  localparam int unsigned CLK_PERIOD_PS = 25000;
  // least cycle length per access, in ns
  localparam int unsigned CYCLE_MIN_NS = 70;
  // write data set-up to write end, in ns
  localparam int unsigned WRITE_DATA_SETUP_NS = 30;
  // read access from strobes to valid data, in ns
  localparam int unsigned READ_ACCESS_NS = 70;
  // cycles from pin change to a filtered word at the sync output
  localparam int unsigned SYNC_CYC = 4;
  // least times round up to whole cycles
  localparam int unsigned CYCLE_MIN_CYC =
    (CYCLE_MIN_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int unsigned SETUP_CYC =
    (WRITE_DATA_SETUP_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int unsigned READ_CYC =
    (READ_ACCESS_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int unsigned CNT_W = 4;
  localparam logic [CNT_W-1:0] CNT_ONE = 4'h1;
  localparam logic [CNT_W-1:0] CNT_ZERO = 4'h0;
  typedef enum logic [2:0] {
    ST_IDLE  = 3'b000,
    ST_SETUP = 3'b001,
    ST_WRITE = 3'b010,
    ST_READ  = 3'b011,
    ST_END   = 3'b100
  } asbp_state_t;
endpackage : asbp_pkg

// ### rtl/asbp_sync.sv
// three-stage input synchroniser with agreement filter
`timescale 1ns/1ps
module asbp_sync #(
  parameter int unsigned W = 16
) (
  input wire logic clk_sys_i,
  input wire logic srst_i,
  input wire logic [W-1:0] async_i,
  output logic [W-1:0] sync_o
);
  logic [W-1:0] s1_q, s2_q, s3_q, out_q;
  logic [W-1:0] out_d;

  // accept a change only once stages two and three agree
  always_comb begin
    out_d = out_q;
    for (int i = 0; i < W; i++) begin
      if (s2_q[i] == s3_q[i]) begin
        out_d[i] = s3_q[i];
      end
    end
  end

  // first stage feeds only the second
  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      s1_q <= '0;
      s2_q <= '0;
      s3_q <= '0;
      out_q <= '0;
    end else begin
      s1_q <= async_i;
      s2_q <= s1_q;
      s3_q <= s2_q;
      out_q <= out_d;
    end
  end

  assign sync_o = out_q;
endmodule : asbp_sync

// ### rtl/asbp_ctrl.sv
// pin-level controller for an asynchronous 256k x 16 static ram
`timescale 1ns/1ps
// Overview of operation
// [RQ1] ram holds 262144 sixteen-bit words, one per address
// [RQ2] write: chip select and write strobe low together store enabled lanes
// [RQ3] low lane enable writes data bits 0 to 7
// [RQ4] high lane enable writes data bits 8 to 15
// [RQ5] read: chip select and output enable low, write strobe high
// [RQ6] low lane enable reads lower byte onto bits 0 to 7
// [RQ7] high lane enable reads upper byte onto bits 8 to 15
// [RQ8] ram floats data whenever deselected, disabled or writing
// [RQ9] chip select high makes ram ignore all other inputs
// [RQ10] write window is overlap of chip select and write strobe low
// [RQ11] either strobe rising ends write; data referenced to first rise
// [RQ12] strobe write with output enable low lasts float delay plus set-up
// [RQ13] ram stays floating when both strobes rise together
// [RQ14] controller never drives data while ram may still drive it
// [RQ15] output enable high keeps ram data floating during writes
// [RQ16] address is valid no later than chip select falling
// [RQ17] each access cycle lasts at least 70 ns
// [RQ18] 18-bit address held stable through the whole access
module asbp_ctrl (
  input wire logic clk_sys_i,
  input wire logic srst_i,
  input wire logic req_valid_i,
  input wire logic req_write_i,
  input wire logic [asbp_pkg::ADDR_W-1:0] req_addr_i,
  input wire logic [asbp_pkg::DATA_W-1:0] req_wdata_i,
  input wire logic [1:0] req_byte_en_i,
  output logic req_ready_o,
  output logic rsp_valid_o,
  output logic [asbp_pkg::DATA_W-1:0] rsp_rdata_o,
  output logic [asbp_pkg::ADDR_W-1:0] sram_addr_o,
  output logic chip_select_n_o,
  output logic write_strobe_n_o,
  output logic output_enable_n_o,
  output logic lower_byte_enable_n_o,
  output logic upper_byte_enable_n_o,
  input wire logic [asbp_pkg::DATA_W-1:0] sram_data_i,
  output logic [asbp_pkg::DATA_W-1:0] sram_data_o,
  output logic sram_data_oe_o
);
  localparam logic [asbp_pkg::CNT_W-1:0] SETUP_N =
    asbp_pkg::CNT_W'(asbp_pkg::SETUP_CYC);
  // read holds the strobes through access time plus the sync path;
  // capturing any earlier would take a word from before the access
  localparam logic [asbp_pkg::CNT_W-1:0] READ_N =
    asbp_pkg::CNT_W'(asbp_pkg::READ_CYC + asbp_pkg::SYNC_CYC);
  localparam logic [asbp_pkg::CNT_W-1:0] CYC_N =
    asbp_pkg::CNT_W'(asbp_pkg::CYCLE_MIN_CYC);

  asbp_pkg::asbp_state_t state_q, state_d;
  logic [asbp_pkg::CNT_W-1:0] cnt_q, cnt_d;
  logic [asbp_pkg::CNT_W-1:0] cyc_q, cyc_d;
  logic [asbp_pkg::ADDR_W-1:0] addr_q, addr_d;
  logic [asbp_pkg::DATA_W-1:0] wdata_q, wdata_d;
  logic [asbp_pkg::DATA_W-1:0] rdata_q, rdata_d;
  logic [1:0] be_q, be_d;
  logic cs_n_q, cs_n_d, we_n_q, we_n_d, oe_n_q, oe_n_d;
  logic doe_q, doe_d, ready_q, ready_d, rvalid_q, rvalid_d;
  logic [asbp_pkg::DATA_W-1:0] data_sync;

  // data pins come from another domain, so they are filtered
  asbp_sync #(
    .W(asbp_pkg::DATA_W)
  ) u_sync (
    .clk_sys_i(clk_sys_i),
    .srst_i(srst_i),
    .async_i(sram_data_i),
    .sync_o(data_sync)
  );

  // access sequencer
  always_comb begin
    state_d = state_q;
    cnt_d = cnt_q;
    cyc_d = (cyc_q != asbp_pkg::CNT_ZERO) ? cyc_q - asbp_pkg::CNT_ONE
                                          : cyc_q;
    addr_d = addr_q;
    wdata_d = wdata_q;
    rdata_d = rdata_q;
    be_d = be_q;
    cs_n_d = cs_n_q;
    we_n_d = we_n_q;
    oe_n_d = oe_n_q;
    doe_d = doe_q;
    ready_d = ready_q;
    rvalid_d = 1'b0;
    unique case (state_q)
      asbp_pkg::ST_IDLE: begin
        if (req_valid_i && ready_q) begin
          // [RQ16] address set in the same cycle as select
          // [RQ18] address latched here
          addr_d = req_addr_i;
          wdata_d = req_wdata_i;
          be_d = ~req_byte_en_i;
          ready_d = 1'b0;
          cs_n_d = 1'b0;
          cyc_d = CYC_N;
          if (req_write_i) begin
            // [RQ15] output enable held high on writes
            oe_n_d = 1'b1;
            // [RQ10] both strobes low open the window
            we_n_d = 1'b0;
            // [RQ14] drive only with ram outputs disabled
            doe_d = 1'b1;
            cnt_d = SETUP_N;
            state_d = asbp_pkg::ST_WRITE;
          end else begin
            // [RQ5] read with write strobe high
            oe_n_d = 1'b0;
            we_n_d = 1'b1;
            cnt_d = READ_N;
            state_d = asbp_pkg::ST_READ;
          end
        end
      end
      asbp_pkg::ST_WRITE: begin
        cnt_d = cnt_q - asbp_pkg::CNT_ONE;
        if (cnt_q == asbp_pkg::CNT_ONE) begin
          // [RQ11] write strobe rises first; data held one more cycle
          we_n_d = 1'b1;
          state_d = asbp_pkg::ST_SETUP;
        end
      end
      asbp_pkg::ST_SETUP: begin
        // [RQ2] release select after data hold
        cs_n_d = 1'b1;
        doe_d = 1'b0;
        state_d = asbp_pkg::ST_END;
      end
      asbp_pkg::ST_READ: begin
        cnt_d = cnt_q - asbp_pkg::CNT_ONE;
        if (cnt_q == asbp_pkg::CNT_ONE) begin
          // [RQ6] [RQ7] capture only the enabled lanes
          for (int i = 0; i < 2; i++) begin
            if (!be_q[i]) begin
              rdata_d[i*asbp_pkg::BYTE_W +: asbp_pkg::BYTE_W] =
                data_sync[i*asbp_pkg::BYTE_W +: asbp_pkg::BYTE_W];
            end
          end
          rvalid_d = 1'b1;
          cs_n_d = 1'b1;
          oe_n_d = 1'b1;
          state_d = asbp_pkg::ST_END;
        end
      end
      asbp_pkg::ST_END: begin
        // [RQ17] hold off the next access until cycle time
        if (cyc_q <= asbp_pkg::CNT_ONE) begin
          ready_d = 1'b1;
          state_d = asbp_pkg::ST_IDLE;
        end
      end
      default: begin
        state_d = asbp_pkg::ST_IDLE;
      end
    endcase
  end

  // register the sequencer
  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      state_q <= asbp_pkg::ST_IDLE;
      cnt_q <= asbp_pkg::CNT_ZERO;
      cyc_q <= asbp_pkg::CNT_ZERO;
      addr_q <= '0;
      wdata_q <= '0;
      rdata_q <= '0;
      be_q <= 2'h3;
      cs_n_q <= 1'b1;
      we_n_q <= 1'b1;
      oe_n_q <= 1'b1;
      doe_q <= 1'b0;
      ready_q <= 1'b1;
      rvalid_q <= 1'b0;
    end else begin
      state_q <= state_d;
      cnt_q <= cnt_d;
      cyc_q <= cyc_d;
      addr_q <= addr_d;
      wdata_q <= wdata_d;
      rdata_q <= rdata_d;
      be_q <= be_d;
      cs_n_q <= cs_n_d;
      we_n_q <= we_n_d;
      oe_n_q <= oe_n_d;
      doe_q <= doe_d;
      ready_q <= ready_d;
      rvalid_q <= rvalid_d;
    end
  end

  // [RQ3] [RQ4] lanes steered by byte enables
  assign sram_addr_o = addr_q;
  assign sram_data_o = wdata_q;
  assign sram_data_oe_o = doe_q;
  assign chip_select_n_o = cs_n_q;
  assign write_strobe_n_o = we_n_q;
  assign output_enable_n_o = oe_n_q;
  assign lower_byte_enable_n_o = be_q[0];
  assign upper_byte_enable_n_o = be_q[1];
  assign req_ready_o = ready_q;
  assign rsp_valid_o = rvalid_q;
  assign rsp_rdata_o = rdata_q;

  // checks
  sequence s_write_open;
    !cs_n_q && !we_n_q;
  endsequence

  // [RQ14] never drive while output enable is low
  a_no_bus_fight: assert property (@(posedge clk_sys_i) disable iff (srst_i)
    !(doe_q && !oe_n_q))
    else $error("data driven while ram outputs enabled");
  // [RQ11] data held while the write window is open
  a_data_held: assert property (@(posedge clk_sys_i) disable iff (srst_i)
    s_write_open |-> doe_q)
    else $error("write window without driven data");
  // [RQ12] write window lasts the set-up count
  a_write_len: assert property (@(posedge clk_sys_i) disable iff (srst_i)
    $fell(we_n_q) |-> !we_n_q [*2] ##1 we_n_q)
    else $error("write strobe width wrong");
  // [RQ18] address stable while selected
  a_addr_stable: assert property (@(posedge clk_sys_i) disable iff (srst_i)
    !cs_n_q && !$past(cs_n_q) |-> $stable(addr_q))
    else $error("address moved during access");
  // [RQ5] read never overlaps write strobe
  a_read_we_high: assert property (@(posedge clk_sys_i) disable iff (srst_i)
    !oe_n_q |-> we_n_q && !cs_n_q)
    else $error("read with write strobe low");
  // [RQ17] no new access taken for two cycles after select falls
  a_cycle_gap: assert property (@(posedge clk_sys_i) disable iff (srst_i)
    $fell(cs_n_q) |-> ##1 (ready_q == 1'b0) [*2])
    else $error("access accepted too soon");
  // [RQ6] read strobes stand through access and sync path
  a_read_len: assert property (@(posedge clk_sys_i) disable iff (srst_i)
    $fell(oe_n_q) |-> !oe_n_q [*7] ##1 oe_n_q) // [RQ7]
    else $error("read strobe width wrong");
  // [RQ6] read answer comes in the cycle select is released
  a_read_rsp: assert property (@(posedge clk_sys_i) disable iff (srst_i)
    rvalid_q |-> cs_n_q && $past(!cs_n_q))
    else $error("read answer without access");
  // [RQ2] write ends with strobe before select
  a_we_first: assert property (@(posedge clk_sys_i) disable iff (srst_i)
    $rose(cs_n_q) && $past(doe_q) |-> $past(we_n_q))
    else $error("select rose before write strobe");
endmodule : asbp_ctrl

// ### bench/asbp_sram_model.sv
// behavioural model of the 256k x 16 static ram seen at its pins
`timescale 1ns/1ps
module asbp_sram_model (
  input wire logic [asbp_pkg::ADDR_W-1:0] addr_i,
  input wire logic chip_select_n_i,
  input wire logic write_strobe_n_i,
  input wire logic output_enable_n_i,
  input wire logic lower_byte_enable_n_i,
  input wire logic upper_byte_enable_n_i,
  input wire logic [asbp_pkg::DATA_W-1:0] bus_i,
  output logic [asbp_pkg::DATA_W-1:0] dq_o,
  output logic [1:0] dq_oe_o
);
  logic [asbp_pkg::DATA_W-1:0] mem_q [0:262143];
  logic wr_on;
  logic rd_on;
  // write window only in the overlap
  assign wr_on = !chip_select_n_i && !write_strobe_n_i;
  // drive only in a clean read
  assign rd_on = !chip_select_n_i && write_strobe_n_i && !output_enable_n_i;
  assign dq_oe_o = {2{rd_on}} & ~{upper_byte_enable_n_i, lower_byte_enable_n_i};
  // instant answer; the controller's synchroniser adds the real delay
  assign dq_o = mem_q[addr_i];
  // store lanes when the first strobe rises
  always @(negedge wr_on) begin
    if (!lower_byte_enable_n_i) begin
      mem_q[addr_i][7:0] = bus_i[7:0];
    end
    if (!upper_byte_enable_n_i) begin
      mem_q[addr_i][15:8] = bus_i[15:8];
    end
  end
endmodule : asbp_sram_model

// ### bench/async_sram_byte_lane_port_test.sv
// self-checking bench for the sram controller against the ram model
`timescale 1ns/1ps
module async_sram_byte_lane_port_test;
  logic clk_sys_i = 1'b0;
  logic srst_i = 1'b1;
  logic req_valid_i = 1'b0;
  logic req_write_i = 1'b0;
  logic [17:0] req_addr_i = 18'h0;
  logic [15:0] req_wdata_i = 16'h0;
  logic [1:0] req_byte_en_i = 2'h0;
  logic req_ready_o, rsp_valid_o, sram_data_oe_o, chip_select_n_o;
  logic write_strobe_n_o, output_enable_n_o;
  logic lower_byte_enable_n_o, upper_byte_enable_n_o;
  logic [15:0] rsp_rdata_o, sram_data_o, dq, bus, exp_rd;
  logic [15:0] flt_q = 16'ha5c3;
  logic [15:0] ref_mem [0:262143];
  logic [17:0] sram_addr_o, addr_q;
  logic [1:0] dq_oe;
  int bad_count = 0;
  int cmp_count = 0;
  int low_cnt = 0;

  always #12.5 clk_sys_i = ~clk_sys_i;

  // floating lanes show a value that changes every cycle
  always @(posedge clk_sys_i) flt_q <= ~flt_q;

  // wire level: controller first, then ram lanes, else float
  always_comb begin
    bus = flt_q;
    if (sram_data_oe_o === 1'b1) begin
      bus = sram_data_o;
    end else begin
      if (dq_oe[0]) bus[7:0] = dq[7:0];
      if (dq_oe[1]) bus[15:8] = dq[15:8];
    end
  end

  asbp_ctrl asbp_ctrl_i (.clk_sys_i(clk_sys_i), .srst_i(srst_i),
    .req_valid_i(req_valid_i), .req_write_i(req_write_i),
    .req_addr_i(req_addr_i), .req_wdata_i(req_wdata_i),
    .req_byte_en_i(req_byte_en_i), .req_ready_o(req_ready_o),
    .rsp_valid_o(rsp_valid_o), .rsp_rdata_o(rsp_rdata_o),
    .sram_addr_o(sram_addr_o), .chip_select_n_o(chip_select_n_o),
    .write_strobe_n_o(write_strobe_n_o),
    .output_enable_n_o(output_enable_n_o),
    .lower_byte_enable_n_o(lower_byte_enable_n_o),
    .upper_byte_enable_n_o(upper_byte_enable_n_o),
    .sram_data_i(bus), .sram_data_o(sram_data_o),
    .sram_data_oe_o(sram_data_oe_o));

  asbp_sram_model asbp_sram_model_i (.addr_i(sram_addr_o),
    .chip_select_n_i(chip_select_n_o), .write_strobe_n_i(write_strobe_n_o),
    .output_enable_n_i(output_enable_n_o),
    .lower_byte_enable_n_i(lower_byte_enable_n_o),
    .upper_byte_enable_n_i(upper_byte_enable_n_o),
    .bus_i(bus), .dq_o(dq), .dq_oe_o(dq_oe));

  task automatic chk(input logic [17:0] got, input logic [17:0] exp);
    cmp_count++;
    if (got !== exp) begin
      bad_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // pin watch at mid-cycle, where everything has settled
  always @(negedge clk_sys_i) begin
    if (sram_data_oe_o === 1'b1) chk(dq_oe, 2'h0);
    if (chip_select_n_o === 1'b0) begin
      if (low_cnt > 0) chk(sram_addr_o, addr_q);
      low_cnt++;
    end else if (low_cnt > 0) begin
      chk(low_cnt >= asbp_pkg::CYCLE_MIN_CYC, 1'b1);
      low_cnt = 0;
    end
    addr_q = sram_addr_o;
  end

  // one request, held until taken; reads compared as whole words, expected lanes updated only where enabled
  task automatic xfer(input logic wr, input logic [17:0] a,
    input logic [15:0] d, input logic [1:0] be);
    int n;
    n = 0;
    @(posedge clk_sys_i);
    req_valid_i <= 1'b1;
    req_write_i <= wr;
    req_addr_i <= a;
    req_wdata_i <= d;
    req_byte_en_i <= be;
    @(negedge clk_sys_i);
    while (req_ready_o !== 1'b1 && n < 12) begin
      @(negedge clk_sys_i);
      n++;
    end
    @(posedge clk_sys_i);
    req_valid_i <= 1'b0;
    do begin
      @(negedge clk_sys_i);
      n++;
    end while ((wr ? req_ready_o : rsp_valid_o) !== 1'b1 && n < 24);
    chk(n < 24, 1'b1);
    if (wr) begin
      if (be[0]) ref_mem[a][7:0] = d[7:0];
      if (be[1]) ref_mem[a][15:8] = d[15:8];
    end else begin
      if (be[0]) exp_rd[7:0] = ref_mem[a][7:0];
      if (be[1]) exp_rd[15:8] = ref_mem[a][15:8];
      chk(rsp_rdata_o, exp_rd);
      @(negedge clk_sys_i);
      chk(rsp_valid_o, 1'b0);
    end
  endtask : xfer

  task automatic t_reset;
    @(negedge clk_sys_i);
    chk({chip_select_n_o, write_strobe_n_o, upper_byte_enable_n_o,
      lower_byte_enable_n_o, sram_data_oe_o, rsp_valid_o}, 18'h3c);
    chk({req_ready_o, sram_addr_o[16:0]}, 18'h20000);
  endtask : t_reset

  // end words of the array, back to back
  task automatic t_words;
    xfer(1'b1, 18'h0, 16'h1234, 2'h3);
    xfer(1'b1, 18'h3ffff, 16'hfedc, 2'h3);
    xfer(1'b0, 18'h0, 16'h0, 2'h3);
    xfer(1'b0, 18'h3ffff, 16'h0, 2'h3);
  endtask : t_words

  // single-lane writes and reads keep the other lane
  task automatic t_lanes;
    xfer(1'b1, 18'h5, 16'hffff, 2'h3);
    xfer(1'b1, 18'h5, 16'h00a1, 2'h1);
    xfer(1'b1, 18'h5, 16'hb200, 2'h2);
    xfer(1'b0, 18'h5, 16'h0, 2'h3);
    xfer(1'b0, 18'h0, 16'h0, 2'h2);
    xfer(1'b0, 18'h3ffff, 16'h0, 2'h1);
  endtask : t_lanes

  task automatic finish_test;
    $display("comparisons=%0d mismatches=%0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : finish_test

  // ten short accesses need well under this
  initial begin
    #100us;
    bad_count++;
    finish_test();
  end

  initial begin
    repeat (4) @(posedge clk_sys_i);
    srst_i <= 1'b0;
    t_reset();
    t_words();
    t_lanes();
    finish_test();
  end
endmodule : async_sram_byte_lane_port_test
